// File: bpc_crc_unit.sv
// bpc_crc_unit: memory-mapped crc calculator behind an axi4-lite slave.
// assumes one 100 MHz clock mclk, synchronous active-high reset, and a
// master that keeps at most one write and one read outstanding.
`timescale 1ns/1ps

module bpc_crc_unit
(
   input  wire logic                           mclk,
   input  wire logic                           reset,
   input  wire logic [bpc_pkg::ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                           s_axi_awvalid,
   output logic                                s_axi_awready,
   input  wire logic [31:0]                    s_axi_wdata,
   input  wire logic [3:0]                     s_axi_wstrb,
   input  wire logic                           s_axi_wvalid,
   output logic                                s_axi_wready,
   output logic [1:0]                          s_axi_bresp,
   output logic                                s_axi_bvalid,
   input  wire logic                           s_axi_bready,
   input  wire logic [bpc_pkg::ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                           s_axi_arvalid,
   output logic                                s_axi_arready,
   output logic [31:0]                         s_axi_rdata,
   output logic [1:0]                          s_axi_rresp,
   output logic                                s_axi_rvalid,
   input  wire logic                           s_axi_rready
);

   // software-visible state
   logic        bitOrderSelect;
   logic [1:0]  polySelect;
   logic [7:0]  crcDataIn;
   logic [15:0] crcResult;

   // write channel holding state
   logic                       awHeld;
   logic                       wHeld;
   logic [bpc_pkg::ADDR_W-1:0] wrAddr;
   logic [31:0]                wrData;
   logic [3:0]                 wrStrb;

   // read channel holding state
   logic                       arHeld;
   logic [bpc_pkg::ADDR_W-1:0] rdAddr;

   // decoded write strobes, write mapped flag and word addresses
   logic        doWrite;
   logic        wrControl;
   logic        wrDataIn;
   logic        wrResult;
   logic        wrMapped;
   logic [11:0] wrWord;
   logic [11:0] rdWord;

   // read mux
   logic [31:0] readValue;
   logic        readMapped;

   // crc datapath
   logic [15:0] next_crcResult;

   // one full byte folded in a single cycle; the loop unrolls into
   // parallel xor trees, it is not a sequential shifter
   function automatic logic [15:0] crcStep
   (
      input logic [15:0] cur,
      input logic [7:0]  din,
      input logic        msbFirst,
      input logic [1:0]  sel
   );
      logic [15:0] acc;
      logic [7:0]  acc8;
      logic [15:0] poly;
      logic [15:0] polyRefl;
      acc      = cur;
      acc8     = cur[7:0];
      poly     = bpc_pkg::POLY16B;
      polyRefl = bpc_pkg::POLY16B_REFL;
      if (sel == bpc_pkg::SEL_POLY16A)
      begin
         poly     = bpc_pkg::POLY16A;
         polyRefl = bpc_pkg::POLY16A_REFL;
      end
      case (sel)
         bpc_pkg::SEL_POLY8:
         begin
            acc8 = acc8 ^ din;
            for (int i = 0; i < 8; i++)
            begin
               if (msbFirst)
               begin
                  if (acc8[7])
                     acc8 = {acc8[6:0], 1'b0} ^ bpc_pkg::POLY8;
                  else
                     acc8 = {acc8[6:0], 1'b0};
               end
               else
               begin
                  if (acc8[0])
                     acc8 = {1'b0, acc8[7:1]} ^ bpc_pkg::POLY8_REFL;
                  else
                     acc8 = {1'b0, acc8[7:1]};
               end
            end
            // the 8-bit code lives in the low byte, upper byte forced clear
            acc = {8'h00, acc8};
         end
         bpc_pkg::SEL_POLY16A, bpc_pkg::SEL_POLY16B:
         begin
            if (msbFirst)
               acc = acc ^ {din, 8'h00};
            else
               acc = acc ^ {8'h00, din};
            for (int i = 0; i < 8; i++)
            begin
               if (msbFirst)
               begin
                  if (acc[15])
                     acc = {acc[14:0], 1'b0} ^ poly;
                  else
                     acc = {acc[14:0], 1'b0};
               end
               else
               begin
                  if (acc[0])
                     acc = {1'b0, acc[15:1]} ^ polyRefl;
                  else
                     acc = {1'b0, acc[15:1]};
               end
            end
         end
         default:
         begin
            // reserved select: no generator, result left untouched
            acc = cur;
         end
      endcase
      return acc;
   endfunction

   // zero initial value and no final inversion, so folding in the code
   // in its transmit byte order drives the remainder to zero
   always_comb
   begin
      next_crcResult = crcStep(crcResult, wrData[7:0], bitOrderSelect,
                               polySelect);
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         s_axi_awready <= 1'b0;
         awHeld        <= 1'b0;
         wrAddr        <= '0;
      end
      else if (s_axi_awready && s_axi_awvalid)
      begin
         s_axi_awready <= 1'b0;
         awHeld        <= 1'b1;
         wrAddr        <= s_axi_awaddr;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
         awHeld <= 1'b0;
      end
      else if (!awHeld)
      begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         s_axi_wready <= 1'b0;
         wHeld        <= 1'b0;
         wrData       <= '0;
         wrStrb       <= '0;
      end
      else if (s_axi_wready && s_axi_wvalid)
      begin
         s_axi_wready <= 1'b0;
         wHeld        <= 1'b1;
         wrData       <= s_axi_wdata;
         wrStrb       <= s_axi_wstrb;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
         wHeld <= 1'b0;
      end
      else if (!wHeld)
      begin
         s_axi_wready <= 1'b1;
      end
   end

   // the write takes effect once, in the cycle both halves are held
   assign doWrite = awHeld && wHeld && !s_axi_bvalid;
   assign wrWord  = {wrAddr[11:2], 2'b00};

   always_comb
   begin
      wrControl = 1'b0;
      wrDataIn  = 1'b0;
      wrResult  = 1'b0;
      wrMapped  = 1'b1;
      if (wrWord == bpc_pkg::OFS_CONTROL)
         wrControl = doWrite;
      else if (wrWord == bpc_pkg::OFS_DATA_IN)
         wrDataIn = doWrite;
      else if (wrWord == bpc_pkg::OFS_RESULT)
         wrResult = doWrite;
      else
         wrMapped = 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= bpc_pkg::RESP_OKAY;
      end
      else if (doWrite)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wrMapped ? bpc_pkg::RESP_OKAY : bpc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // the clear bit and reserved bits are never stored
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         bitOrderSelect <= bpc_pkg::RST_CONTROL[bpc_pkg::BIT_ORDER];
         polySelect     <= bpc_pkg::RST_CONTROL[bpc_pkg::POLY_HI:bpc_pkg::POLY_LO];
      end
      else if (wrControl && wrStrb[0])
      begin
         bitOrderSelect <= wrData[bpc_pkg::BIT_ORDER];
         polySelect     <= wrData[bpc_pkg::POLY_HI:bpc_pkg::POLY_LO];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         crcDataIn <= bpc_pkg::RST_DATA_IN;
      else if (wrDataIn && wrStrb[0])
         crcDataIn <= wrData[7:0];
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         crcResult <= bpc_pkg::RST_RESULT;
      end
      else if (wrControl && wrStrb[0] && wrData[bpc_pkg::BIT_CLEAR])
      begin
         crcResult <= bpc_pkg::RST_RESULT;
      end
      else if (wrDataIn && wrStrb[0])
      begin
         // uses the captured byte, so data and fold always agree
         crcResult <= next_crcResult;
      end
      else if (wrResult)
      begin
         if (wrStrb[0])
            crcResult[7:0] <= wrData[7:0];
         if (wrStrb[1])
            crcResult[15:8] <= wrData[15:8];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         s_axi_arready <= 1'b0;
         arHeld        <= 1'b0;
         rdAddr        <= '0;
      end
      else if (s_axi_arready && s_axi_arvalid)
      begin
         s_axi_arready <= 1'b0;
         arHeld        <= 1'b1;
         rdAddr        <= s_axi_araddr;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         arHeld <= 1'b0;
      end
      else if (!arHeld)
      begin
         s_axi_arready <= 1'b1;
      end
   end

   assign rdWord = {rdAddr[11:2], 2'b00};

   always_comb
   begin
      readValue  = 32'h0000_0000;
      readMapped = 1'b1;
      if (rdWord == bpc_pkg::OFS_CONTROL)
      begin
         // clear bit is write-only and reserved bits are zero
         readValue[bpc_pkg::BIT_ORDER] = bitOrderSelect;
         readValue[bpc_pkg::POLY_HI:bpc_pkg::POLY_LO] = polySelect;
      end
      else if (rdWord == bpc_pkg::OFS_DATA_IN)
      begin
         readValue[7:0] = crcDataIn;
      end
      else if (rdWord == bpc_pkg::OFS_RESULT)
      begin
         readValue[15:0] = crcResult;
      end
      else
      begin
         readMapped = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= bpc_pkg::RESP_OKAY;
      end
      else if (arHeld && !s_axi_rvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= readValue;
         s_axi_rresp  <= readMapped ? bpc_pkg::RESP_OKAY : bpc_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// File: bpc_crc_unit_monitor.sv
// bpc_crc_unit_monitor: bus-side assertions for the crc unit.
// assumes it is bound to bpc_crc_unit and sees only its ports.
`timescale 1ns/1ps
module bpc_crc_unit_monitor
(
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_b_answer;
      s_wr_take |-> ##2 s_axi_bvalid;
   endproperty
   a_b_answer: assert property (p_b_answer) else $error("no write answer");
   property p_b_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_b_block: assert property (p_b_block) else $error("write taken early");
   property p_r_answer;
      s_rd_take |-> ##2 (s_axi_rvalid && !s_axi_arready);
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("no read answer");
   property p_ctl_read;
      s_rd_take ##0 s_axi_araddr == 12'h000 |-> ##2 s_axi_rdata[31:3] == 29'h0;
   endproperty
   a_ctl_read: assert property (p_ctl_read) else $error("control bits 7..3");
   property p_din_read;
      s_rd_take ##0 s_axi_araddr == 12'h004 |-> ##2 s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_din_read: assert property (p_din_read) else $error("data in too wide");
   property p_res_read;
      s_rd_take ##0 s_axi_araddr == 12'h008 |-> ##2 s_axi_rdata[31:16] == 16'h0;
   endproperty
   a_res_read: assert property (p_res_read) else $error("result too wide");
   property p_r_okay;
      s_rd_take ##0 s_axi_araddr[11:2] <= 10'h2 |-> ##2 s_axi_rresp == 2'b00;
   endproperty
   a_r_okay: assert property (p_r_okay) else $error("mapped read refused");
   property p_unmapped;
      s_rd_take ##0 s_axi_araddr[11:2] > 10'h2
         |-> ##2 (s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule
bind bpc_crc_unit bpc_crc_unit_monitor bpc_crc_unit_monitor_inst
   (.mclk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid);

// File: bpc_crc_unit_tb.sv
// bpc_crc_unit_tb: self-checking bench for the crc unit over axi4-lite.
// assumes the 100 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
   $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module bpc_crc_unit_tb;
   logic        mclk = 0, reset = 1;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0]  wstrb = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [33:0] rq[$];
   logic [1:0]  bq[$];
   logic [33:0] rexp;
   logic [1:0]  bexp;
   int          failures = 0, checked = 0;
   logic [15:0] exp;
   logic [7:0]  b, last;
   always #5 mclk = ~mclk;
   bpc_crc_unit bpc_crc_unit_inst
   (
      .mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );
   // bit-serial reference; lsb-first runs on the mirrored generator
   function automatic logic [15:0] crcf(logic [15:0] c, logic [7:0] d, logic m,
                                        logic [1:0] g);
      logic [15:0] p;
      logic [15:0] q;
      logic        e;
      e = (g == 2'b01);
      p = e ? 16'h0007 : (g == 2'b10 ? 16'h8005 : 16'h1021);
      if (e) c = {8'h00, c[7:0]};
      if (m)
      begin
         if (e) {c, p} = {c << 8, p << 8};
         c ^= {d, 8'h00};
         repeat (8) c = c[15] ? (c << 1) ^ p : c << 1;
         if (e) c = c >> 8;
      end
      else
      begin
         for (int i = 0; i < 16; i++) q[i] = p[15 - i];
         p = e ? q >> 8 : q;
         c ^= {8'h00, d};
         repeat (8) c = c[0] ? (c >> 1) ^ p : c >> 1;
      end
      return c;
   endfunction
   task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] r);
      bit aw = 1, w = 1;
      bq.push_back(r);
      @(posedge mclk);
      {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, s, 3'b111};
      while (aw || w)
      begin
         @(posedge mclk);
         if (aw && awready) begin aw = 0; awvalid <= 0; end
         if (w && wready) begin w = 0; wvalid <= 0; end
      end
      while (!bvalid) @(posedge mclk);
      bready <= 0;
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] d, logic [1:0] r = 2'b00);
      rq.push_back({r, d});
      @(posedge mclk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      do @(posedge mclk); while (!arready);
      arvalid <= 0;
      do @(posedge mclk); while (!rvalid);
      rready <= 0;
   endtask
   task automatic byt(logic [7:0] v);
      wr(12'h004, {24'h0, v}, 4'h1, 2'b00);
   endtask
   task results;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // compares land in the edge's active region, before the design's updates
   always @(posedge mclk)
   begin
      // the note is taken off once, so a mismatch report cannot pop a second one
      if (!reset && rvalid && rready)
      begin
         rexp = rq.pop_front();
         `CHK({rresp, rdata}, rexp)
      end
      if (!reset && bvalid && bready)
      begin
         bexp = bq.pop_front();
         `CHK(bresp, bexp)
      end
   end
   initial
   begin
      repeat (20000) @(posedge mclk);
      failures++;
      results();
   end
   initial
   begin
      void'($urandom(32'he444));
      repeat (10) @(posedge mclk);
      reset <= 0;
      @(posedge mclk);
      rd(12'h000, 32'h0000_0000);
      rd(12'h004, 32'h0000_0000);
      rd(12'h008, 32'h0000_0000);
      wr(12'h008, 32'h0000_A5C3, 4'h3, 2'b00);
      rd(12'h008, 32'h0000_A5C3);
      wr(12'h000, 32'h0000_0083, 4'h1, 2'b00);
      rd(12'h000, 32'h0000_0003);
      rd(12'h008, 32'h0000_0000);
      wr(12'h000, 32'h0000_0080, 4'h1, 2'b00);
      byt(8'h5A);
      rd(12'h004, 32'h0000_005A);
      rd(12'h008, 32'h0000_0000);
      wr(12'h00C, 32'h0000_0055, 4'hF, 2'b10);
      rd(12'h00C, 32'h0000_0000, 2'b10);
      for (int g = 1; g < 4; g++)
         for (int m = 0; m < 2; m++)
         begin
            wr(12'h000, {24'h0, 1'b1, 4'h0, m[0], g[1:0]}, 4'h1, 2'b00);
            rd(12'h000, {29'h0, m[0], g[1:0]});
            exp = 16'h0000;
            repeat (1 + m + g)
            begin
               b = 8'($urandom);
               last = b;
               byt(b);
               exp = crcf(exp, b, m[0], g[1:0]);
            end
            rd(12'h004, {24'h0, last});
            rd(12'h008, {16'h0, exp});
            if (g == 1) byt(exp[7:0]);
            else if (m) begin byt(exp[15:8]); byt(exp[7:0]); end
            else begin byt(exp[7:0]); byt(exp[15:8]); end
            rd(12'h008, 32'h0000_0000);
         end
      results();
   end
endmodule

// File: bpc_pkg.sv
// bpc_pkg: constants of the byte-parallel crc unit.
// assumes a 32-bit axi4-lite register bus and a single system clock.
package bpc_pkg;
   localparam int          ADDR_W         = 12;
   localparam logic [11:0] OFS_CONTROL    = 12'h000;
   localparam logic [11:0] OFS_DATA_IN    = 12'h004;
   localparam logic [11:0] OFS_RESULT     = 12'h008;
   // control register fields
   localparam int          BIT_CLEAR      = 7;
   localparam int          BIT_ORDER      = 2;
   localparam int          POLY_HI        = 1;
   localparam int          POLY_LO        = 0;
   localparam logic [7:0]  RST_CONTROL    = 8'h00;
   localparam logic [7:0]  RST_DATA_IN    = 8'h00;
   localparam logic [15:0] RST_RESULT     = 16'h0000;
   // polynomial select codes
   localparam logic [1:0]  SEL_RESERVED   = 2'b00;
   localparam logic [1:0]  SEL_POLY8      = 2'b01;
   localparam logic [1:0]  SEL_POLY16A    = 2'b10;
   localparam logic [1:0]  SEL_POLY16B    = 2'b11;
   // generator terms below the top power, normal and bit-reflected
   localparam logic [7:0]  POLY8          = 8'h07;
   localparam logic [7:0]  POLY8_REFL     = 8'hE0;
   localparam logic [15:0] POLY16A        = 16'h8005;
   localparam logic [15:0] POLY16A_REFL   = 16'hA001;
   localparam logic [15:0] POLY16B        = 16'h1021;
   localparam logic [15:0] POLY16B_REFL   = 16'h8408;
   // axi response codes
   localparam logic [1:0]  RESP_OKAY      = 2'b00;
   localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage
